// ### rtl/fbm_link_setup.sv
// fieldbus master link setup: address source, cycle tick, revision check, capture enable
// Notes on behaviour
// - node address from host station or alias
// - cycle period 500/1000/2000/4000 us, default 500
// - revision check off accepts all, default
// - common high-word mode compares upper word
// - common full mode compares whole revision
// - common low-word mode compares lower word
// - individual mode uses per-slave compare method
// - capture request flag honoured only when enabled
// - capture starts after power-up when set
`timescale 1ns/1ns
module fbm_link_setup #(
	parameter int NODES = 64,
	parameter int AW    = 6
) (
	// clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  rst_n_i,
	// configuration from host software
	input  wire logic                  cfg_load_i,
	input  wire logic [0:0]            cfg_addr_src_i,
	input  wire logic [1:0]            cfg_cycle_i,
	input  wire logic [2:0]            cfg_rev_mode_i,
	input  wire logic                  cfg_flag_capture_en_i,
	input  wire logic                  cfg_poweron_capture_i,
	input  wire logic [31:0]           cfg_expected_rev_i,
	// per-slave method table write
	input  wire logic                  meth_wr_i,
	input  wire logic [AW-1:0]         meth_addr_i,
	input  wire logic [2:0]            meth_data_i,
	// slave check request
	input  wire logic                  chk_req_i,
	input  wire logic [AW-1:0]         chk_node_i,
	input  wire logic [31:0]           chk_rev_i,
	input  wire logic [15:0]           chk_station_addr_i,
	input  wire logic [15:0]           chk_alias_addr_i,
	output logic                       chk_busy_o,
	output logic                       chk_done_o,
	output logic                       chk_accept_o,
	output logic [15:0]                chk_node_addr_o,
	// capture control
	input  wire logic                  capture_request_flag_i,
	output logic                       capture_start_o,
	// cycle timing
	output logic                       cycle_tick_o,
	// state readback
	output logic [1:0]                 cur_cycle_o,
	output logic [2:0]                 cur_rev_mode_o
);

	// cycle counts derived from microseconds and clock rate
	localparam int C500  = fbm_pkg::FBM_PERIOD_500_US  * fbm_pkg::FBM_CLK_MHZ;
	localparam int C1000 = fbm_pkg::FBM_PERIOD_1000_US * fbm_pkg::FBM_CLK_MHZ;
	localparam int C2000 = fbm_pkg::FBM_PERIOD_2000_US * fbm_pkg::FBM_CLK_MHZ;
	localparam int C4000 = fbm_pkg::FBM_PERIOD_4000_US * fbm_pkg::FBM_CLK_MHZ;

	if (NODES > (1 << AW)) begin : g_bad_nodes
		$error("fbm_link_setup: NODES exceeds AW");
	end

	//////////////////////////////////////////////////////////////////
	// functions

	// revision compare per method; halves
	function automatic logic rev_ok(input logic [2:0] m, input logic [31:0] got,
			input logic [31:0] exp);
		logic r;
		r = 1'b1;
		case (m)
			fbm_pkg::FBM_REV_OFF:  r = 1'b1;
			fbm_pkg::FBM_REV_HIGH: r = (got[fbm_pkg::FBM_REV_W-1 -: fbm_pkg::FBM_HALF_W] ==
				exp[fbm_pkg::FBM_REV_W-1 -: fbm_pkg::FBM_HALF_W]);
			fbm_pkg::FBM_REV_FULL: r = (got == exp);
			fbm_pkg::FBM_REV_LOW:  r = (got[fbm_pkg::FBM_HALF_W-1:0] ==
				exp[fbm_pkg::FBM_HALF_W-1:0]);
			default:               r = 1'b0; // unknown method rejects
		endcase
		return r;
	endfunction : rev_ok

	// period count for a selection code, minus one for a wrap at zero
	function automatic logic [16:0] period_last(input logic [1:0] c);
		logic [16:0] p;
		p = 17'(C500 - 1);
		case (c)
			fbm_pkg::FBM_CYC_500:  p = 17'(C500 - 1);
			fbm_pkg::FBM_CYC_1000: p = 17'(C1000 - 1);
			fbm_pkg::FBM_CYC_2000: p = 17'(C2000 - 1);
			fbm_pkg::FBM_CYC_4000: p = 17'(C4000 - 1);
			default:               p = 17'(C500 - 1);
		endcase
		return p;
	endfunction : period_last

	//////////////////////////////////////////////////////////////////
	// configuration registers

	logic [0:0]  addr_src_q, addr_src_d;   // address source
	logic [1:0]  cycle_q, cycle_d;         // period code
	logic [2:0]  rev_mode_q, rev_mode_d;   // check mode
	logic        flag_en_q, flag_en_d;     // honour request flag
	logic        pwr_cap_q, pwr_cap_d;     // capture after power-up
	logic [31:0] exp_rev_q, exp_rev_d;     // expected revision

	// load new settings when host strobes
	always_comb begin
		addr_src_d = addr_src_q;
		cycle_d    = cycle_q;
		rev_mode_d = rev_mode_q;
		flag_en_d  = flag_en_q;
		pwr_cap_d  = pwr_cap_q;
		exp_rev_d  = exp_rev_q;
		if (cfg_load_i) begin
			addr_src_d = cfg_addr_src_i;
			cycle_d    = cfg_cycle_i;
			// reserved mode codes fall back to off
			rev_mode_d = (cfg_rev_mode_i > fbm_pkg::FBM_REV_INDIV) ?
				fbm_pkg::FBM_REV_OFF : cfg_rev_mode_i;
			flag_en_d  = cfg_flag_capture_en_i;
			pwr_cap_d  = cfg_poweron_capture_i;
			exp_rev_d  = cfg_expected_rev_i;
		end
	end

	// defaults at reset: host address, 500 us, check off, captures off
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			addr_src_q <= fbm_pkg::FBM_RST_ADDR_SRC;
			cycle_q    <= fbm_pkg::FBM_RST_CYCLE;
			rev_mode_q <= fbm_pkg::FBM_RST_REV_MODE;
			flag_en_q  <= 1'b0;
			pwr_cap_q  <= 1'b0;
			exp_rev_q  <= '0;
		end else begin
			addr_src_q <= addr_src_d;
			cycle_q    <= cycle_d;
			rev_mode_q <= rev_mode_d;
			flag_en_q  <= flag_en_d;
			pwr_cap_q  <= pwr_cap_d;
			exp_rev_q  <= exp_rev_d;
		end
	end

	//////////////////////////////////////////////////////////////////
	// cycle timer; a new period applies from the cycle after the load, so a
	// running cycle already past the new period's end wraps at once

	logic [16:0] tmr_q, tmr_d;   // cycles into the period
	logic        tick_q, tick_d; // registered tick

	always_comb begin
		tick_d = 1'b0;
		if (tmr_q >= period_last(cycle_q)) begin
			tmr_d  = '0;
			tick_d = 1'b1;
		end else begin
			tmr_d = tmr_q + 17'h00001;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tmr_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			tmr_q  <= tmr_d;
			tick_q <= tick_d;
		end
	end

	//////////////////////////////////////////////////////////////////
	// per-slave method table

	logic [2:0] meth_rd; // method of requested node, one cycle late

	fbm_table #(
		.DEPTH (NODES),
		.AW    (AW),
		.DW    (fbm_pkg::FBM_METHOD_W)
	) u_table (
		.clk_i     (clk_i),
		.rst_n_i   (rst_n_i),
		.wr_en_i   (meth_wr_i),
		.wr_addr_i (meth_addr_i),
		.wr_data_i (meth_data_i),
		.rd_addr_i (chk_node_i),
		.rd_data_o (meth_rd)
	);

	//////////////////////////////////////////////////////////////////
	// slave check sequence: idle -> fetch (table read) -> cmp -> done

	fbm_pkg::fbm_state_type st_q, st_d;
	logic [31:0] rev_q, rev_d;       // captured slave revision
	logic [15:0] naddr_q, naddr_d;   // resolved node address
	logic        acc_q, acc_d;       // verdict
	logic [2:0]  meth;               // effective method

	// common modes ignore the table; individual mode uses it
	always_comb begin
		meth = (rev_mode_q == fbm_pkg::FBM_REV_INDIV) ? meth_rd : rev_mode_q;
	end

	always_comb begin
		st_d    = st_q;
		rev_d   = rev_q;
		naddr_d = naddr_q;
		acc_d   = acc_q;
		case (st_q)
			fbm_pkg::FBM_ST_IDLE: begin
				if (chk_req_i) begin
					rev_d   = chk_rev_i;
					naddr_d = (addr_src_q == fbm_pkg::FBM_ADDR_ALIAS) ?
						chk_alias_addr_i : chk_station_addr_i;
					st_d    = fbm_pkg::FBM_ST_FETCH;
				end
			end
			fbm_pkg::FBM_ST_FETCH: st_d = fbm_pkg::FBM_ST_CMP;
			fbm_pkg::FBM_ST_CMP: begin
				acc_d = rev_ok(meth, rev_q, exp_rev_q);
				st_d  = fbm_pkg::FBM_ST_DONE;
			end
			fbm_pkg::FBM_ST_DONE: st_d = fbm_pkg::FBM_ST_IDLE;
			default:              st_d = fbm_pkg::FBM_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q    <= fbm_pkg::FBM_ST_IDLE;
			rev_q   <= '0;
			naddr_q <= '0;
			acc_q   <= 1'b0;
		end else begin
			st_q    <= st_d;
			rev_q   <= rev_d;
			naddr_q <= naddr_d;
			acc_q   <= acc_d;
		end
	end

	//////////////////////////////////////////////////////////////////
	// capture start: one pulse after power-up if enabled, and on a
	// rising request flag while flag capture is enabled

	logic boot_q, boot_d;     // power-up slot already used
	logic flag_q, flag_d;     // last flag level
	logic cap_q, cap_d;       // start pulse

	always_comb begin
		boot_d = 1'b1;
		flag_d = capture_request_flag_i;
		cap_d  = 1'b0;
		// first cycle after reset release; setting reads its reset value
		// unless loaded in that same cycle
		if (!boot_q && pwr_cap_d) begin
			cap_d = 1'b1;
		end
		if (flag_en_q && capture_request_flag_i && !flag_q) begin
			cap_d = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			boot_q <= 1'b0;
			flag_q <= 1'b0;
			cap_q  <= 1'b0;
		end else begin
			boot_q <= boot_d;
			flag_q <= flag_d;
			cap_q  <= cap_d;
		end
	end

	//////////////////////////////////////////////////////////////////
	// outputs

	assign chk_busy_o      = (st_q != fbm_pkg::FBM_ST_IDLE);
	assign chk_done_o      = (st_q == fbm_pkg::FBM_ST_DONE);
	assign chk_accept_o    = acc_q;
	assign chk_node_addr_o = naddr_q;
	assign capture_start_o = cap_q;
	assign cycle_tick_o    = tick_q;
	assign cur_cycle_o     = cycle_q;
	assign cur_rev_mode_o  = rev_mode_q;

endmodule : fbm_link_setup

// ### rtl/fbm_pkg.sv
// package of constants and types for the fieldbus master link setup block
package fbm_pkg;

	// node address source selection
	typedef enum logic [0:0] {
		FBM_ADDR_HOST  = 1'b0, // station address from the host tool (default)
		FBM_ADDR_ALIAS = 1'b1  // each slave's own alias setting
	} fbm_addr_src_type;

	// cycle period selection codes
	typedef enum logic [1:0] {
		FBM_CYC_500  = 2'b00,
		FBM_CYC_1000 = 2'b01,
		FBM_CYC_2000 = 2'b10,
		FBM_CYC_4000 = 2'b11
	} fbm_cycle_type;

	// revision check modes; per-slave methods use the first four codes
	typedef enum logic [2:0] {
		FBM_REV_OFF   = 3'b000,
		FBM_REV_HIGH  = 3'b001,
		FBM_REV_FULL  = 3'b010,
		FBM_REV_LOW   = 3'b011,
		FBM_REV_INDIV = 3'b100
	} fbm_rev_mode_type;

	// checker state machine
	typedef enum logic [1:0] {
		FBM_ST_IDLE  = 2'b00,
		FBM_ST_FETCH = 2'b01,
		FBM_ST_CMP   = 2'b10,
		FBM_ST_DONE  = 2'b11
	} fbm_state_type;

	// cycle periods in microseconds
	localparam int FBM_PERIOD_500_US  = 500;
	localparam int FBM_PERIOD_1000_US = 1000;
	localparam int FBM_PERIOD_2000_US = 2000;
	localparam int FBM_PERIOD_4000_US = 4000;
	// clock rate in megahertz
	localparam int FBM_CLK_MHZ        = 25;
	// revision word split
	localparam int FBM_REV_W          = 32;
	localparam int FBM_HALF_W         = 16;
	localparam int FBM_METHOD_W       = 3;

	// reset values
	localparam logic [0:0] FBM_RST_ADDR_SRC  = 1'b0;
	localparam logic [1:0] FBM_RST_CYCLE     = 2'b00;
	localparam logic [2:0] FBM_RST_REV_MODE  = 3'b000;

endpackage : fbm_pkg

// ### rtl/fbm_table.sv
// small memory holding the per-slave revision compare method
`timescale 1ns/1ns
module fbm_table #(
	parameter int DEPTH = 64,
	parameter int AW    = 6,
	parameter int DW    = 3
) (
	// clock and reset
	input  wire logic          clk_i,
	input  wire logic          rst_n_i,
	// write port
	input  wire logic          wr_en_i,
	input  wire logic [AW-1:0] wr_addr_i,
	input  wire logic [DW-1:0] wr_data_i,
	// read port
	input  wire logic [AW-1:0] rd_addr_i,
	output logic      [DW-1:0] rd_data_o
);

	logic [DW-1:0] mem_q [DEPTH];   // method per slave
	logic [DW-1:0] rd_q;            // registered read data
	logic [DW-1:0] rd_d;

	if (DEPTH > (1 << AW)) begin : g_bad_depth
		$error("fbm_table: DEPTH too large for AW");
	end

	//////////////////////////////////////////////////////////////////
	// read next value; contents unreset so plain ram can be inferred
	always_comb begin
		rd_d = mem_q[rd_addr_i];
	end

	// storage write, no reset
	always_ff @(posedge clk_i) begin
		if (wr_en_i) begin
			mem_q[wr_addr_i] <= wr_data_i;
		end
	end

	// registered read
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_q <= '0;
		end else begin
			rd_q <= rd_d;
		end
	end

	assign rd_data_o = rd_q;

endmodule : fbm_table

// ### verif/fbm_link_props.sv
// assertion checker for the fieldbus master link setup block
`timescale 1ns/1ns
module fbm_link_props (
	// clock and reset
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	// settings
	input wire logic        cfg_load_i,
	input wire logic [0:0]  cfg_addr_src_i,
	input wire logic [1:0]  cfg_cycle_i,
	input wire logic [2:0]  cfg_rev_mode_i,
	input wire logic        cfg_flag_capture_en_i,
	// slave check
	input wire logic        chk_req_i,
	input wire logic [15:0] chk_station_addr_i,
	input wire logic [15:0] chk_alias_addr_i,
	input wire logic        chk_busy_o,
	input wire logic        chk_done_o,
	input wire logic        chk_accept_o,
	input wire logic [15:0] chk_node_addr_o,
	// capture and timing
	input wire logic        capture_request_flag_i,
	input wire logic        capture_start_o,
	input wire logic        cycle_tick_o,
	input wire logic [1:0]  cur_cycle_o,
	input wire logic [2:0]  cur_rev_mode_o
);
	logic src_q; // address source as loaded
	logic fen_q; // flag capture enable as loaded
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	////////////////////////////////////////
	// shadow of the settings the outputs do not show
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			src_q <= 1'b0;
			fen_q <= 1'b0;
		end else if (cfg_load_i) begin
			src_q <= cfg_addr_src_i[0];
			fen_q <= cfg_flag_capture_en_i;
		end
	end
	////////////////////////////////////////
	a_check_latency: assert property (!chk_busy_o && chk_req_i |=> chk_busy_o ##2 chk_done_o)
		else $error("check verdict not three cycles after take");
	a_done_single: assert property (chk_done_o |=> !chk_done_o && !chk_busy_o)
		else $error("done not a lone pulse ending busy");
	a_addr_source: assert property (!chk_busy_o && chk_req_i |=>
		chk_node_addr_o == ($past(src_q) ? $past(chk_alias_addr_i) : $past(chk_station_addr_i)))
		else $error("node address from wrong source");
	a_cycle_load: assert property (cfg_load_i |=> cur_cycle_o == $past(cfg_cycle_i))
		else $error("cycle code not loaded");
	a_mode_load: assert property (cfg_load_i |=> cur_rev_mode_o ==
		(($past(cfg_rev_mode_i) > 3'h4) ? 3'h0 : $past(cfg_rev_mode_i)))
		else $error("revision mode not loaded");
	a_settings_hold: assert property (!cfg_load_i |=> $stable(cur_cycle_o) && $stable(cur_rev_mode_o))
		else $error("settings moved without load");
	a_off_accepts: assert property (chk_done_o && cur_rev_mode_o == 3'h0 |-> chk_accept_o)
		else $error("check off refused a slave");
	a_flag_capture: assert property ($rose(capture_request_flag_i) && fen_q |-> ##[1:2] capture_start_o)
		else $error("enabled flag gave no capture");
	a_tick_pulse: assert property (cycle_tick_o |=> !cycle_tick_o)
		else $error("cycle tick longer than one cycle");
	c_done: cover property (chk_done_o && !chk_accept_o);
	c_capture: cover property (capture_start_o);
	c_tick: cover property (cycle_tick_o);
endmodule : fbm_link_props
bind fbm_link_setup fbm_link_props fbm_link_props_inst (.*);

// ### verif/fbm_slave_model.sv
// slave device model: revision and node addresses per node
`timescale 1ns/1ns
module fbm_slave_model (
	// clock
	input  wire logic        clk_i,
	// revision programming by the bench
	input  wire logic        set_i,
	input  wire logic [5:0]  node_i,
	input  wire logic [31:0] rev_i,
	// answers seen by the master
	output logic      [31:0] rev_o,
	output logic      [15:0] station_o,
	output logic      [15:0] alias_o
);
	logic [31:0] rev_mem [64]; // revision each slave reports
	// bench sets a slave's revision before it is checked
	always_ff @(posedge clk_i) begin
		if (set_i) begin
			rev_mem[node_i] <= rev_i;
		end
	end
	assign rev_o     = rev_mem[node_i];
	assign station_o = {10'h040, node_i}; // address given by the host tool
	assign alias_o   = {10'h3a5, node_i} ^ 16'h00ff; // slave's own alias, differs on purpose
endmodule : fbm_slave_model

// ### verif/tb_top.sv
// self-checking bench for the fieldbus master link setup block
`timescale 1ns/1ns
module tb_top;
	logic        clk_i = 1'b0, rst_n_i = 1'b0, cfg_load_i = 1'b0, set_q = 1'b0;
	logic [0:0]  cfg_addr_src_i = 1'b0;
	logic [1:0]  cfg_cycle_i = 2'h0, cur_cycle_o;
	logic [2:0]  cfg_rev_mode_i = 3'h0, meth_data_i = 3'h0, cur_rev_mode_o, m, mt;
	logic        cfg_flag_capture_en_i = 1'b0, cfg_poweron_capture_i = 1'b0, meth_wr_i = 1'b0;
	logic [31:0] cfg_expected_rev_i = 32'h0, rev_set = 32'h0, chk_rev_i, e, r;
	logic [5:0]  meth_addr_i = 6'h0, chk_node_i = 6'h0, n;
	logic        chk_req_i = 1'b0, capture_request_flag_i = 1'b0, s;
	logic [15:0] chk_station_addr_i, chk_alias_addr_i, chk_node_addr_o;
	logic        chk_busy_o, chk_done_o, chk_accept_o, capture_start_o, cycle_tick_o;
	int          fail_count = 0, n_tests = 0, i, c;
	fbm_slave_model fbm_slave_model_inst (.clk_i(clk_i), .set_i(set_q), .node_i(chk_node_i),
		.rev_i(rev_set), .rev_o(chk_rev_i), .station_o(chk_station_addr_i),
		.alias_o(chk_alias_addr_i));
	fbm_link_setup fbm_link_setup_inst (.*);
	initial forever #20 clk_i = ~clk_i;
	////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic test_done();
		$display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : test_done
	// a wait that ran out counts against the run
	task automatic hung();
		fail_count++;
		test_done();
	endtask : hung
	// expected verdict for one compare method
	function automatic logic f_acc(input logic [2:0] md, input logic [31:0] rv, input logic [31:0] ex);
		case (md)
			3'h0: return 1'b1;
			3'h1: return rv[31:16] == ex[31:16];
			3'h2: return rv == ex;
			3'h3: return rv[15:0] == ex[15:0];
			default: return 1'b0; // unknown per-slave method rejects
		endcase
	endfunction : f_acc
	task automatic count_caps(input int len, output int cnt);
		cnt = 0;
		repeat (len) begin
			@(negedge clk_i);
			cnt += 32'(capture_start_o === 1'b1);
		end
	endtask : count_caps
	// reset, optionally loading power-on capture at the first edge
	task automatic do_reset(input logic p);
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		cfg_load_i <= p;
		cfg_poweron_capture_i <= p;
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		cfg_load_i <= 1'b0;
		cfg_poweron_capture_i <= 1'b0;
		count_caps(4, c);
		chk(32'(c), 32'(p));
		chk(32'({cur_cycle_o, cur_rev_mode_o}), 32'h0);
	endtask : do_reset
	task automatic cfg(input logic sc, input logic [1:0] cy, input logic [2:0] md, input logic f);
		@(posedge clk_i);
		cfg_load_i <= 1'b1;
		{cfg_addr_src_i, cfg_cycle_i, cfg_rev_mode_i, cfg_flag_capture_en_i} <= {sc, cy, md, f};
		cfg_expected_rev_i <= e;
		@(posedge clk_i);
		cfg_load_i <= 1'b0;
		@(negedge clk_i);
		chk(32'(cur_cycle_o), 32'(cy));
		chk(32'(cur_rev_mode_o), (md > 3'h4) ? 32'h0 : 32'(md));
	endtask : cfg
	// program slave revision, request a check, compare verdict and address
	task automatic check(input logic ea, input logic [15:0] eaddr);
		int k;
		@(posedge clk_i);
		{set_q, chk_node_i, rev_set, meth_wr_i, meth_addr_i, meth_data_i} <= {1'b1, n, r, 1'b1, n, mt};
		@(posedge clk_i);
		{set_q, meth_wr_i, chk_req_i} <= 3'b001;
		@(posedge clk_i);
		chk_req_i <= 1'b0;
		for (k = 0; k < 8 && chk_done_o !== 1'b1; k++) @(negedge clk_i);
		if (k == 8) hung();
		chk(32'(chk_accept_o), 32'(ea));
		chk(32'(chk_node_addr_o), 32'(eaddr));
	endtask : check
	task automatic tick_gap(input int exp);
		int k;
		for (k = 0; k < 110000 && cycle_tick_o !== 1'b1; k++) @(negedge clk_i);
		if (k == 110000) hung();
		@(negedge clk_i);
		for (k = 1; k < 110000 && cycle_tick_o !== 1'b1; k++) @(negedge clk_i);
		if (k == 110000) hung();
		chk(32'(k), 32'(exp));
	endtask : tick_gap
	////////////////////////////////////////
	initial begin
		void'($urandom(32'h7d00afc5));
		do_reset(1'b0);
		do_reset(1'b1);
		// every mode and reserved code, each with match, high and low word miss
		for (i = 0; i < 24; i++) begin
			m = 3'(i % 8);
			e = $urandom;
			n = 6'($urandom);
			s = 1'($urandom);
			mt = 3'($urandom);
			r = e ^ ((i / 8 == 1) ? (32'h1 << (16 + $urandom % 16)) : (i / 8 == 2) ? (32'h1 << ($urandom % 16)) : 32'h0);
			cfg(s, 2'(i), m, 1'b0);
			check((m == 3'h4) ? f_acc(mt, r, e) : f_acc((m > 3'h4) ? 3'h0 : m, r, e), s ? ({10'h3a5, n} ^ 16'h00ff) : {10'h040, n});
		end
		// capture flag ignored, then honoured
		for (i = 0; i < 2; i++) begin
			cfg(1'b0, 2'h0, 3'h0, 1'(i));
			@(posedge clk_i);
			capture_request_flag_i <= 1'b1;
			count_caps(6, c);
			@(posedge clk_i);
			capture_request_flag_i <= 1'b0;
			chk(32'(c), 32'(i));
		end
		tick_gap(fbm_pkg::FBM_PERIOD_500_US * fbm_pkg::FBM_CLK_MHZ);
		cfg(1'b0, 2'h1, 3'h0, 1'b0);
		tick_gap(fbm_pkg::FBM_PERIOD_1000_US * fbm_pkg::FBM_CLK_MHZ);
		test_done();
	end
endmodule : tb_top
